// ==== verilog/timer16_params.svh ====
// constants for the 16-bit timer waveform block
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH
`define ADDR_CTRL_A 4'h0
`define ADDR_CTRL_B 4'h1
`define ADDR_CMP_A_LO 4'h2
`define ADDR_CMP_A_HI 4'h3
`define ADDR_CMP_B_LO 4'h4
`define ADDR_CMP_B_HI 4'h5
`define ADDR_CAP_LO 4'h6
`define ADDR_CAP_HI 4'h7
`define ADDR_CNT_LO 4'h8
`define ADDR_CNT_HI 4'h9
`define ADDR_FLAGS 4'ha
`define ADDR_DIR 4'hb
`define CTRL_RESET 8'h00
`define CTRL_B_MASK 8'h18
`define CTRL_A_RD_MASK 8'hf3
`define BIT_FORCE_A 3
`define BIT_FORCE_B 2
`define BIT_WAVE_HI 3
`define TOP_MAX 16'hffff
`define TOP_8 16'h00ff
`define TOP_9 16'h01ff
`define TOP_10 16'h03ff
`define MODE_NORMAL 4'h0
`define MODE_PC8 4'h1
`define MODE_PC9 4'h2
`define MODE_PC10 4'h3
`define MODE_CTC_CMP 4'h4
`define MODE_FAST8 4'h5
`define MODE_FAST9 4'h6
`define MODE_FAST10 4'h7
`define MODE_PFC_CAP 4'h8
`define MODE_PFC_CMP 4'h9
`define MODE_PC_CAP 4'ha
`define MODE_PC_CMP 4'hb
`define MODE_CTC_CAP 4'hc
`define MODE_FAST_CAP 4'he
`define MODE_FAST_CMP 4'hf
`define OM_OFF 2'b00
`define OM_TOGGLE 2'b01
`define OM_CLEAR 2'b10
`define OM_SET 2'b11
`endif

// ==== verilog/timer16_pkg.sv ====
// types for the 16-bit timer waveform block
package timer16_pkg;
  typedef enum logic [1:0] {wave_normal, wave_fast, wave_dual} wave_kind_e;
  typedef struct packed {
    logic [15:0] top;
    wave_kind_e kind;
    logic buf_at_top;
    logic buf_at_bottom;
    logic ovf_at_top;
    logic ovf_at_bottom;
    logic clear_on_top;
  } mode_info_s;
endpackage : timer16_pkg

// ==== verilog/timer16_wave_out.sv ====
// one compare output channel: waveform action and pin drive
`include "timer16_params.svh"
module timer16_wave_out
  import timer16_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst, // async reset
  input wire logic [1:0] out_mode, // channel output mode
  input wire wave_kind_e kind, // waveform kind
  input wire logic toggle_ok, // mode allows toggle
  input wire logic match, // compare match this cycle
  input wire logic match_is_top, // compare value equals top
  input wire logic at_top, // counter at top
  input wire logic counting_up, // dual slope direction
  input wire logic force_strobe, // forced compare
  input wire logic dir_out, // port direction is output
  input wire logic port_val, // normal port value
  output logic pin_out, // pin level
  output logic pin_oe_n // pin enable, low drives
);
  logic wave_ff;
  logic nxt_wave;
  logic connected;

  always_comb begin
    nxt_wave = wave_ff;
    case (kind)
      wave_normal: begin
        if (match || force_strobe) begin
          case (out_mode)
            `OM_TOGGLE: nxt_wave = ~wave_ff;
            `OM_CLEAR: nxt_wave = 1'b0;
            `OM_SET: nxt_wave = 1'b1;
            default: nxt_wave = wave_ff;
          endcase
        end
      end
      wave_fast: begin
        if (out_mode == `OM_TOGGLE) begin
          if (toggle_ok && match) begin
            nxt_wave = ~wave_ff;
          end
        end else if (out_mode[1]) begin
          if (at_top) begin
            nxt_wave = ~out_mode[0];
          end else if (match && !match_is_top) begin
            nxt_wave = out_mode[0];
          end
        end
      end
      wave_dual: begin
        if (out_mode == `OM_TOGGLE) begin
          if (toggle_ok && match) begin
            nxt_wave = ~wave_ff;
          end
        end else if (out_mode[1] && match) begin
          nxt_wave = counting_up ? out_mode[0] : ~out_mode[0];
        end
      end
      default: nxt_wave = wave_ff;
    endcase
  end

  assign connected = (out_mode == `OM_TOGGLE) ? toggle_ok : (out_mode != `OM_OFF);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wave_ff <= 1'b0;
    end else begin
      wave_ff <= nxt_wave;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out <= connected ? nxt_wave : port_val;
      pin_oe_n <= ~dir_out;
    end
  end
endmodule : timer16_wave_out

// ==== verilog/timer16_waveform_mode_control.sv ====
// 16-bit timer: control registers, counter sequence, compare buffering and outputs
//
// Overview of operation
// - nonzero channel A output mode hands its pin to the compare output, 01 only where toggle is allowed
// - nonzero channel B output mode hands its pin to the compare output, 01 only in non-PWM modes
// - pin is driven only when its direction bit selects output
// - non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM: 10 clear on match set at top; 11 inverse
// - fast PWM toggle mode 01 only channel A in mode 15
// - fast PWM 10/11: match at top ignored, top action still done
// - dual-slope toggle 01 only channel A in mode 9
// - dual-slope: 10 clear up, set down; 11 inverse
// - force strobe applies a match action in non-PWM modes only
// - forced match sets no flag and never clears counter
// - force bits always read back as zero
// - two low mode bits plus two high bits form the mode
// - mode 0: top 0xffff, immediate update, overflow at max
// - mode 4 clears on compare A, mode 12 on capture
// - modes 1-3 dual slope, fixed tops, buffer at top, flag at bottom
// - modes 5-7, 14, 15 fast PWM; buffer and flag at top
// - modes 8, 9 phase-frequency correct; buffer and flag at bottom
// - modes 10, 11 phase correct; buffer at top, flag at bottom
// - high mode bits at 4:3 of second control register, reset zero
`include "timer16_params.svh"
module timer16_waveform_mode_control
  import timer16_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst, // async reset
  input wire logic [3:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic timer_tick, // timer clock enable
  input wire logic port_a_val, // normal port value pin a
  input wire logic port_b_val, // normal port value pin b
  output logic [7:0] reg_rdata, // read data
  output logic compare_pin_a_out, // pin a level
  output logic compare_pin_a_oe_n, // pin a enable, low drives
  output logic compare_pin_b_out, // pin b level
  output logic compare_pin_b_oe_n, // pin b enable, low drives
  output logic overflow_flag // overflow flag
);
  logic [7:0] ctrl_a_ff;
  logic [7:0] ctrl_b_ff;
  logic [15:0] cmp_a_buf_ff;
  logic [15:0] cmp_b_buf_ff;
  logic [15:0] cmp_a_ff;
  logic [15:0] cmp_b_ff;
  logic [15:0] capture_reg_ff;
  logic [15:0] count_ff;
  logic [7:0] temp_ff;
  logic [1:0] dir_ff;
  logic down_ff;
  logic ovf_ff;
  logic cmp_a_hit_ff;
  logic cmp_b_hit_ff;
  logic [3:0] wave_mode_select;
  logic [1:0] wave_mode_low;
  logic [1:0] wave_mode_high;
  logic [1:0] chan_a_output_mode;
  logic [1:0] chan_b_output_mode;
  mode_info_s mi;
  logic ctrl_a_wr;
  logic force_a;
  logic force_b;
  logic at_top;
  logic at_bottom;
  logic at_max;
  logic match_a;
  logic match_b;
  logic toggle_ok_a;
  logic toggle_ok_b;
  logic cnt_written;

  // --------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------
  function automatic mode_info_s decode_mode(input logic [3:0] m, input logic [15:0] cmp_a,
                                             input logic [15:0] cap);
    mode_info_s r;
    r = '{top: `TOP_MAX, kind: wave_normal, buf_at_top: 1'b0, buf_at_bottom: 1'b0,
          ovf_at_top: 1'b0, ovf_at_bottom: 1'b0, clear_on_top: 1'b0};
    case (m)
      `MODE_NORMAL: r.top = `TOP_MAX;
      `MODE_CTC_CMP: begin
        r.top = cmp_a;
        r.clear_on_top = 1'b1;
      end
      `MODE_CTC_CAP: begin
        r.top = cap;
        r.clear_on_top = 1'b1;
      end
      `MODE_PC8, `MODE_PC9, `MODE_PC10, `MODE_PC_CAP, `MODE_PC_CMP: begin
        r.kind = wave_dual;
        r.buf_at_top = 1'b1;
        r.ovf_at_bottom = 1'b1;
      end
      `MODE_PFC_CAP, `MODE_PFC_CMP: begin
        r.kind = wave_dual;
        r.buf_at_bottom = 1'b1;
        r.ovf_at_bottom = 1'b1;
      end
      `MODE_FAST8, `MODE_FAST9, `MODE_FAST10, `MODE_FAST_CAP, `MODE_FAST_CMP: begin
        r.kind = wave_fast;
        r.buf_at_top = 1'b1;
        r.ovf_at_top = 1'b1;
        r.clear_on_top = 1'b1;
      end
      default: r.top = `TOP_MAX;
    endcase
    case (m)
      `MODE_PC8, `MODE_FAST8: r.top = `TOP_8;
      `MODE_PC9, `MODE_FAST9: r.top = `TOP_9;
      `MODE_PC10, `MODE_FAST10: r.top = `TOP_10;
      `MODE_PFC_CAP, `MODE_PC_CAP, `MODE_FAST_CAP: r.top = cap;
      `MODE_PFC_CMP, `MODE_PC_CMP, `MODE_FAST_CMP: r.top = cmp_a;
      default: r.top = r.top;
    endcase
    return r;
  endfunction : decode_mode

  // --------------------------------------------------------------
  // channel a toggle decode
  // --------------------------------------------------------------
  function automatic logic toggle_allowed(input wave_kind_e k, input logic [3:0] m);
    logic ok;
    ok = 1'b0;
    case (k)
      wave_normal: ok = 1'b1;
      wave_fast: ok = (m == `MODE_FAST_CMP);
      wave_dual: ok = (m == `MODE_PFC_CMP) || (m == `MODE_FAST_CAP);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : toggle_allowed

  assign wave_mode_low = ctrl_a_ff[1:0];
  assign wave_mode_high = ctrl_b_ff[`BIT_WAVE_HI + 1:`BIT_WAVE_HI];
  assign wave_mode_select = {wave_mode_high, wave_mode_low};
  assign chan_a_output_mode = ctrl_a_ff[7:6];
  assign chan_b_output_mode = ctrl_a_ff[5:4];
  assign mi = decode_mode(wave_mode_select, cmp_a_ff, capture_reg_ff);

  assign ctrl_a_wr = reg_wr && (reg_addr == `ADDR_CTRL_A);
  assign force_a = ctrl_a_wr && reg_wdata[`BIT_FORCE_A] && (mi.kind == wave_normal);
  assign force_b = ctrl_a_wr && reg_wdata[`BIT_FORCE_B] && (mi.kind == wave_normal);
  assign cnt_written = reg_wr && (reg_addr == `ADDR_CNT_LO);

  assign at_top = timer_tick && (count_ff == mi.top);
  assign at_bottom = timer_tick && (count_ff == 16'h0000);
  assign at_max = timer_tick && (count_ff == `TOP_MAX);
  // forced matches never reach the counter or the flags
  assign match_a = timer_tick && (count_ff == cmp_a_ff) && !cmp_a_hit_ff;
  assign match_b = timer_tick && (count_ff == cmp_b_ff) && !cmp_b_hit_ff;
  assign toggle_ok_a = toggle_allowed(mi.kind, wave_mode_select);
  // channel b never toggles in a PWM mode
  assign toggle_ok_b = (mi.kind == wave_normal);

  // --------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_a_ff <= `CTRL_RESET;
      ctrl_b_ff <= `CTRL_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_CTRL_A: ctrl_a_ff <= reg_wdata & `CTRL_A_RD_MASK;
        `ADDR_CTRL_B: ctrl_b_ff <= reg_wdata & `CTRL_B_MASK;
        default: ctrl_a_ff <= ctrl_a_ff;
      endcase
    end
  end

  // port direction bits gate the pin drivers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dir_ff <= 2'b00;
    end else if (reg_wr && (reg_addr == `ADDR_DIR)) begin
      dir_ff <= reg_wdata[1:0];
    end
  end

  // --------------------------------------------------------------
  // 16-bit registers through a shared high byte
  // --------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      temp_ff <= 8'h00;
      cmp_a_buf_ff <= 16'h0000;
      cmp_b_buf_ff <= 16'h0000;
      capture_reg_ff <= 16'h0000;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_CMP_A_HI, `ADDR_CMP_B_HI, `ADDR_CAP_HI, `ADDR_CNT_HI: temp_ff <= reg_wdata;
        `ADDR_CMP_A_LO: cmp_a_buf_ff <= {temp_ff, reg_wdata};
        `ADDR_CMP_B_LO: cmp_b_buf_ff <= {temp_ff, reg_wdata};
        `ADDR_CAP_LO: capture_reg_ff <= {temp_ff, reg_wdata};
        default: temp_ff <= temp_ff;
      endcase
    end
  end

  // compare registers load from buffers per mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmp_a_ff <= 16'h0000;
      cmp_b_ff <= 16'h0000;
    end else if ((mi.kind == wave_normal) || (mi.buf_at_top && at_top) ||
                 (mi.buf_at_bottom && at_bottom)) begin
      cmp_a_ff <= cmp_a_buf_ff;
      cmp_b_ff <= cmp_b_buf_ff;
    end
  end

  // --------------------------------------------------------------
  // counter
  // --------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_ff <= 16'h0000;
      down_ff <= 1'b0;
    end else if (cnt_written) begin
      count_ff <= {temp_ff, reg_wdata};
    end else if (timer_tick) begin
      if (mi.kind == wave_dual) begin
        if (count_ff >= mi.top) begin
          down_ff <= 1'b1;
          count_ff <= count_ff - 16'h0001;
        end else if (down_ff && count_ff == 16'h0000) begin
          down_ff <= 1'b0;
          count_ff <= 16'h0001;
        end else begin
          count_ff <= down_ff ? count_ff - 16'h0001 : count_ff + 16'h0001;
        end
      end else begin
        down_ff <= 1'b0;
        count_ff <= (mi.clear_on_top && at_top) ? 16'h0000 : count_ff + 16'h0001;
      end
    end
  end

  // a counter write blocks a compare match on the next timer tick
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmp_a_hit_ff <= 1'b0;
      cmp_b_hit_ff <= 1'b0;
    end else if (cnt_written) begin
      cmp_a_hit_ff <= 1'b1;
      cmp_b_hit_ff <= 1'b1;
    end else if (timer_tick) begin
      cmp_a_hit_ff <= 1'b0;
      cmp_b_hit_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // overflow flag, write one to clear, set wins
  // --------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovf_ff <= 1'b0;
    end else if ((mi.kind == wave_normal && at_max) || (mi.ovf_at_top && at_top) ||
                 (mi.ovf_at_bottom && at_bottom && down_ff)) begin
      ovf_ff <= 1'b1;
    end else if (reg_wr && reg_addr == `ADDR_FLAGS && reg_wdata[0]) begin
      ovf_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= ovf_ff;
    end
  end

  // --------------------------------------------------------------
  // read port
  // --------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_CTRL_A: reg_rdata <= ctrl_a_ff & `CTRL_A_RD_MASK;
        `ADDR_CTRL_B: reg_rdata <= ctrl_b_ff;
        `ADDR_CMP_A_LO: reg_rdata <= cmp_a_buf_ff[7:0];
        `ADDR_CMP_A_HI: reg_rdata <= cmp_a_buf_ff[15:8];
        `ADDR_CMP_B_LO: reg_rdata <= cmp_b_buf_ff[7:0];
        `ADDR_CMP_B_HI: reg_rdata <= cmp_b_buf_ff[15:8];
        `ADDR_CAP_LO: reg_rdata <= capture_reg_ff[7:0];
        `ADDR_CAP_HI: reg_rdata <= capture_reg_ff[15:8];
        `ADDR_CNT_LO: reg_rdata <= count_ff[7:0];
        `ADDR_CNT_HI: reg_rdata <= count_ff[15:8];
        `ADDR_FLAGS: reg_rdata <= {7'h00, ovf_ff};
        `ADDR_DIR: reg_rdata <= {6'h00, dir_ff};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // --------------------------------------------------------------
  // output channels
  // --------------------------------------------------------------
  timer16_wave_out u_chan_a (
    .core_clk(core_clk),
    .rst(rst),
    .out_mode(chan_a_output_mode),
    .kind(mi.kind),
    .toggle_ok(toggle_ok_a),
    .match(match_a),
    .match_is_top(cmp_a_ff == mi.top),
    .at_top(at_top),
    .counting_up(!down_ff),
    .force_strobe(force_a),
    .dir_out(dir_ff[0]),
    .port_val(port_a_val),
    .pin_out(compare_pin_a_out),
    .pin_oe_n(compare_pin_a_oe_n)
  );

  timer16_wave_out u_chan_b (
    .core_clk(core_clk),
    .rst(rst),
    .out_mode(chan_b_output_mode),
    .kind(mi.kind),
    .toggle_ok(toggle_ok_b),
    .match(match_b),
    .match_is_top(cmp_b_ff == mi.top),
    .at_top(at_top),
    .counting_up(!down_ff),
    .force_strobe(force_b),
    .dir_out(dir_ff[1]),
    .port_val(port_b_val),
    .pin_out(compare_pin_b_out),
    .pin_oe_n(compare_pin_b_oe_n)
  );
endmodule : timer16_waveform_mode_control

// ==== bench/timer16_waveform_mode_control_props.sv ====
// checker for the 16-bit timer waveform block
`include "timer16_params.svh"
module timer16_waveform_mode_control_props
  import timer16_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst, // async reset
  input wire logic [3:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic timer_tick, // timer clock enable
  input wire logic port_a_val, // port value a
  input wire logic port_b_val, // port value b
  input wire logic [7:0] reg_rdata, // read data
  input wire logic compare_pin_a_out, // pin a level
  input wire logic compare_pin_a_oe_n, // pin a enable
  input wire logic compare_pin_b_out, // pin b level
  input wire logic compare_pin_b_oe_n, // pin b enable
  input wire logic overflow_flag // overflow flag
);
  // ----------------------------------------
  // shadow of software-visible settings
  // ----------------------------------------
  logic [7:0] ctrl_a_ff;
  logic [1:0] wave_hi_ff;
  logic [1:0] dir_ff;
  logic force_ok;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_a_ff <= 8'h00;
    end else if (reg_wr && reg_addr == `ADDR_CTRL_A) begin
      ctrl_a_ff <= reg_wdata & `CTRL_A_RD_MASK;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wave_hi_ff <= 2'b00;
    end else if (reg_wr && reg_addr == `ADDR_CTRL_B) begin
      wave_hi_ff <= reg_wdata[4:3];
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dir_ff <= 2'b00;
    end else if (reg_wr && reg_addr == `ADDR_DIR) begin
      dir_ff <= reg_wdata[1:0];
    end
  end
  // control a write while mode 0, 4 or 12 runs
  assign force_ok = reg_wr && reg_addr == `ADDR_CTRL_A && ctrl_a_ff[1:0] == 2'b00 && wave_hi_ff != 2'b10;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_ctrl_a_read;
    $past(reg_rd) && $past(reg_addr) == `ADDR_CTRL_A |-> reg_rdata == $past(ctrl_a_ff);
  endproperty
  a_ctrl_a_read: assert property (p_ctrl_a_read)
    else $error("control a readback wrong");
  property p_ctrl_b_read;
    $past(reg_rd) && $past(reg_addr) == `ADDR_CTRL_B |-> reg_rdata == {3'b000, $past(wave_hi_ff), 3'b000};
  endproperty
  a_ctrl_b_read: assert property (p_ctrl_b_read)
    else $error("control b readback wrong");
  property p_oe_a;
    $stable(dir_ff) |-> compare_pin_a_oe_n == ~dir_ff[0];
  endproperty
  a_oe_a: assert property (p_oe_a)
    else $error("pin a enable wrong");
  property p_oe_b;
    $stable(dir_ff) |-> compare_pin_b_oe_n == ~dir_ff[1];
  endproperty
  a_oe_b: assert property (p_oe_b)
    else $error("pin b enable wrong");
  property p_pin_a_port;
    !$past(rst) && ctrl_a_ff[7:6] == 2'b00 && $past(ctrl_a_ff[7:6]) == 2'b00 |-> compare_pin_a_out == $past(port_a_val);
  endproperty
  a_pin_a_port: assert property (p_pin_a_port)
    else $error("pin a not on port logic");
  property p_pin_b_port;
    !$past(rst) && ctrl_a_ff[5:4] == 2'b00 && $past(ctrl_a_ff[5:4]) == 2'b00 |-> compare_pin_b_out == $past(port_b_val);
  endproperty
  a_pin_b_port: assert property (p_pin_b_port)
    else $error("pin b not on port logic");
  property p_force_a;
    force_ok && reg_wdata[`BIT_FORCE_A] && ctrl_a_ff[7:6] == `OM_SET |-> ##[1:2] compare_pin_a_out;
  endproperty
  a_force_a: assert property (p_force_a)
    else $error("forced set on pin a missing");
  property p_force_b;
    force_ok && reg_wdata[`BIT_FORCE_B] && ctrl_a_ff[5:4] == `OM_CLEAR |-> ##[1:2] !compare_pin_b_out;
  endproperty
  a_force_b: assert property (p_force_b)
    else $error("forced clear on pin b missing");
  property p_toggle_off_a;
    !$past(rst) && $past(ctrl_a_ff[7:6]) == `OM_TOGGLE && $past(wave_hi_ff) == 2'b01 && $past(ctrl_a_ff[1:0]) != 2'b00
      |-> compare_pin_a_out == $past(port_a_val);
  endproperty
  a_toggle_off_a: assert property (p_toggle_off_a)
    else $error("pin a toggle not disconnected");
  property p_toggle_off_b;
    !$past(rst) && $past(ctrl_a_ff[5:4]) == `OM_TOGGLE && $past(ctrl_a_ff[1:0]) != 2'b00 && $past(wave_hi_ff) != 2'b11
      |-> compare_pin_b_out == $past(port_b_val);
  endproperty
  a_toggle_off_b: assert property (p_toggle_off_b)
    else $error("pin b toggle not disconnected");
endmodule : timer16_waveform_mode_control_props

bind timer16_waveform_mode_control timer16_waveform_mode_control_props i_timer16_waveform_mode_control_props (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .timer_tick(timer_tick), .port_a_val(port_a_val), .port_b_val(port_b_val),
  .reg_rdata(reg_rdata), .compare_pin_a_out(compare_pin_a_out), .compare_pin_a_oe_n(compare_pin_a_oe_n),
  .compare_pin_b_out(compare_pin_b_out), .compare_pin_b_oe_n(compare_pin_b_oe_n), .overflow_flag(overflow_flag)
);

// ==== bench/tb_timer16_waveform_mode_control.sv ====
// self-checking testbench for the 16-bit timer waveform block
`include "timer16_params.svh"
module tb_timer16_waveform_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic timer_tick = 1'b0;
  logic port_a_val = 1'b0;
  logic port_b_val = 1'b0;
  logic [7:0] reg_rdata;
  logic pin_a, oe_a_n, pin_b, oe_b_n, ovf;
  int err_total = 0;
  int checks = 0;

  timer16_waveform_mode_control i_timer16_waveform_mode_control (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .timer_tick(timer_tick), .port_a_val(port_a_val), .port_b_val(port_b_val),
    .reg_rdata(reg_rdata), .compare_pin_a_out(pin_a), .compare_pin_a_oe_n(oe_a_n),
    .compare_pin_b_out(pin_b), .compare_pin_b_oe_n(oe_b_n), .overflow_flag(ovf)
  );

  always #25 core_clk = ~core_clk;
  // random port levels exercise the disconnected path
  always @(posedge core_clk) begin
    port_a_val <= 1'($urandom);
    port_b_val <= 1'($urandom);
  end

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a + 4'h1, v[15:8]);
    wr(a, v[7:0]);
  endtask : wr16
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  // high samples per single counter period
  function automatic int fast_high(input int ocr, input bit inv, input int top);
    return inv ? top - ocr : ocr + 1;
  endfunction : fast_high
  function automatic int dual_high(input int ocr, input bit inv, input int top);
    return inv ? 2 * (top - ocr) : 2 * ocr;
  endfunction : dual_high
  task automatic run(input int settle, input int n, output int ha, output int hb);
    @(posedge core_clk);
    timer_tick <= 1'b1;
    repeat (settle) @(negedge core_clk);
    ha = 0;
    hb = 0;
    repeat (n) begin
      @(negedge core_clk);
      ha += int'(pin_a);
      hb += int'(pin_b);
    end
  endtask : run

  initial begin
    #1000000;
    err_total++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    logic ea;
    logic last;
    int ha, hb, tg, ocr;
    logic [3:0] md [3] = '{`MODE_NORMAL, `MODE_CTC_CMP, `MODE_CTC_CAP};
    logic [1:0] com [4] = '{`OM_SET, `OM_CLEAR, `OM_TOGGLE, `OM_TOGGLE};
    void'($urandom(32'h874309cd));
    ea = 1'b0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(`ADDR_CTRL_A, d);
    check("ctrl a reset", d, `CTRL_RESET);
    rd(`ADDR_CTRL_B, d);
    check("ctrl b reset", d, 8'h00);
    check("oe a reset", oe_a_n, 1'b1);
    check("oe b reset", oe_b_n, 1'b1);
    wr(`ADDR_CTRL_A, 8'hfc);
    rd(`ADDR_CTRL_A, d);
    check("ctrl a read", d, 8'hf0);
    wr(`ADDR_CTRL_B, 8'hff);
    rd(`ADDR_CTRL_B, d);
    check("ctrl b read", d, `CTRL_B_MASK);
    wr(4'hc, 8'h5a);
    rd(4'hc, d);
    check("unmapped", d, 8'h00);
    wr(`ADDR_DIR, 8'h03);
    repeat (2) @(negedge core_clk);
    check("oe a out", oe_a_n, 1'b0);
    check("oe b out", oe_b_n, 1'b0);
    // forced actions in modes 0, 4 and 12
    foreach (md[m]) begin
      wr(`ADDR_CTRL_B, {3'b000, md[m][3:2], 3'b000});
      foreach (com[c]) begin
        // the strobe acts on the output mode already stored
        wr(`ADDR_CTRL_A, {com[c], com[c], 2'b00, md[m][1:0]});
        wr(`ADDR_CTRL_A, {com[c], com[c], 2'b11, md[m][1:0]});
        ea = (com[c] == `OM_SET) ? 1'b1 : (com[c] == `OM_CLEAR) ? 1'b0 : ~ea;
        repeat (2) @(negedge core_clk);
        check("forced pin a", pin_a, ea);
        check("forced pin b", pin_b, ea);
      end
    end
    check("no flag on force", ovf, 1'b0);
    // clear-on-match toggling, period of 10 ticks
    wr16(`ADDR_CMP_A_LO, 16'h0009);
    wr(`ADDR_CTRL_B, 8'h08);
    wr(`ADDR_CTRL_A, 8'h40);
    run(20, 1, ha, hb);
    tg = 0;
    last = pin_a;
    repeat (200) begin
      @(negedge core_clk);
      if (pin_a !== last) tg++;
      last = pin_a;
    end
    check("ctc toggles", 16'(tg), 16'h0014);
    // fast PWM, 8-bit, random compare values
    for (int inv = 0; inv < 2; inv++) begin
      @(posedge core_clk);
      timer_tick <= 1'b0;
      ocr = $urandom_range(16'h00fd, 2);
      wr16(`ADDR_CMP_A_LO, 16'(ocr));
      wr16(`ADDR_CMP_B_LO, 16'(ocr));
      wr(`ADDR_CTRL_B, 8'h08);
      wr(`ADDR_CTRL_A, inv ? 8'hf1 : 8'ha1);
      run(600, 512, ha, hb);
      check("fast duty a", 16'(ha), 16'(2 * fast_high(ocr, inv[0], `TOP_8)));
      check("fast duty b", 16'(hb), 16'(2 * fast_high(ocr, inv[0], `TOP_8)));
    end
    // toggle mode 01 stays disconnected in fast 8-bit mode
    wr(`ADDR_CTRL_A, 8'h51);
    repeat (300) @(negedge core_clk);
    check("ovf at top", ovf, 1'b1);
    @(posedge core_clk);
    timer_tick <= 1'b0;
    wr(`ADDR_FLAGS, 8'h01);
    repeat (2) @(negedge core_clk);
    check("ovf cleared", ovf, 1'b0);
    // phase correct 8-bit, a non-inverted and b inverted
    ocr = $urandom_range(16'h00fd, 2);
    wr16(`ADDR_CMP_A_LO, 16'(ocr));
    wr16(`ADDR_CMP_B_LO, 16'(ocr));
    wr(`ADDR_CTRL_B, 8'h00);
    wr(`ADDR_CTRL_A, 8'hb1);
    run(1100, 1020, ha, hb);
    check("dual duty a", 16'(ha), 16'(2 * dual_high(ocr, 1'b0, `TOP_8)));
    check("dual duty b", 16'(hb), 16'(2 * dual_high(ocr, 1'b1, `TOP_8)));
    stop_test();
  end
endmodule : tb_timer16_waveform_mode_control
